/* File: design/ocw_defines.svh */
// Purpose: constants for the cpu clock select and oscillator loss monitor
// Assumes: included by its bare name
// Notes:   widths, field positions, reset values, counts and codes only
`ifndef OCW_DEFINES_SVH
`define OCW_DEFINES_SVH
// system config register: width, monitor disable field, reset value
`define OCW_CFG_WIDTH        16
`define OCW_CFG_MON_DIS_BIT  4
`define OCW_CFG_RESET        16'h0000
// monitor counter overflows after this many free-running pll cycles
`define OCW_MON_OVF_CYCLES   16
`define OCW_MON_CNT_WIDTH    4
// reset-sampled mode pin codes
`define OCW_MODE_X4          3'h7
`define OCW_MODE_X3          3'h6
`define OCW_MODE_X2          3'h5
`define OCW_MODE_X5          3'h4
`define OCW_MODE_DIRECT      3'h3
`define OCW_MODE_X1P5        3'h2
`define OCW_MODE_PRESCALE    3'h1
`define OCW_MODE_X2P5        3'h0
`define OCW_MODE_DEFAULT     3'h7
// pll factor in halves (factor times two)
`define OCW_FX2_X4           4'h8
`define OCW_FX2_X3           4'h6
`define OCW_FX2_X2           4'h4
`define OCW_FX2_X5           4'hA
`define OCW_FX2_X1P5         4'h3
`define OCW_FX2_X2P5         4'h5
`define OCW_FX2_NONE         4'h0
`endif

/* File: design/ocw_pkg.sv */
// Purpose: types for the cpu clock select and oscillator loss monitor
// Assumes: constants live in ocw_defines.svh
// Notes:   one-hot codes written out
package ocw_pkg;
  // cpu clock source
  typedef enum logic [2:0]
  {
    OCW_SRC_OSC      = 3'h1,  // oscillator input, direct or prescaled
    OCW_SRC_PLL_FREE = 3'h2,  // pll free-running, after loss of clock
    OCW_SRC_PLL_LOCK = 3'h4   // pll multiplying the oscillator input
  } ocw_src_type;

  // clock generation kind latched at reset
  typedef enum logic [2:0]
  {
    OCW_KIND_DIRECT   = 3'h1,
    OCW_KIND_PRESCALE = 3'h2,
    OCW_KIND_PLL      = 3'h4
  } ocw_kind_type;

  // status bundle driven to the rest of the chip
  typedef struct packed
  {
    ocw_src_type  src;        // current cpu clock source
    ocw_kind_type kind;       // reset-latched generation kind
    logic [3:0]   factor_x2;  // pll factor times two, zero when unused
    logic         pll_on;     // pll powered
    logic         mon_on;     // loss monitor active
  } ocw_status_type;
endpackage : ocw_pkg

/* File: design/ocw_sync.sv */
// Purpose: two-flop synchroniser with transition detect
// Assumes: inputs are asynchronous to i_clk_sys
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module ocw_sync
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             i_clk_sys,
  input  wire logic             i_sys_rst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync,
  output logic      [WIDTH-1:0] o_edge
);
  logic [WIDTH-1:0] meta_ff;  // first stage, read only by sync_ff
  logic [WIDTH-1:0] sync_ff;  // second stage
  logic [WIDTH-1:0] prev_ff;  // delayed copy for transition detect

  // elaboration check: a zero-width chain has nothing to synchronise
  if (WIDTH < 1)
  begin : g_width_check
    $error("ocw_sync width must be at least one");
  end

  ////////////////////////////////////////////////////////////////////////
  // synchroniser chain
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
      prev_ff <= '0;
    end
    else
    begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign o_sync = sync_ff;
  // either direction counts as a transition
  assign o_edge = sync_ff ^ prev_ff;
endmodule : ocw_sync

/* File: design/ocw_clock_select.sv */
// Purpose: cpu clock source select with oscillator loss monitor
// Assumes: i_clk_sys stands for the pll free-running clock, one tick a cycle
// Notes:   the pll itself is analog; this logic steers and times it
`timescale 1ns/1ps
`include "ocw_defines.svh"
module ocw_clock_select
  import ocw_pkg::*;
#(
  parameter int MON_CNT_WIDTH  = `OCW_MON_CNT_WIDTH,
  parameter int MON_OVF_CYCLES = `OCW_MON_OVF_CYCLES
)
(
  input  wire logic                      i_clk_sys,
  input  wire logic                      i_sys_rst,
  input  wire logic                      i_osc_input_pin,
  input  wire logic [2:0]                i_clock_mode_pins,
  input  wire logic                      i_cfg_wr,
  input  wire logic [`OCW_CFG_WIDTH-1:0] i_cfg_wdata,
  input  wire logic                      i_irq_clr,
  output logic [`OCW_CFG_WIDTH-1:0]      o_system_config_reg,
  output logic                           o_osc_fail_irq,
  output logic                           o_cpu_clk_tick,
  output logic                           o_pll_resync,
  output ocw_status_type                 o_status
);
  logic                     osc_sync;      // synchronised oscillator level
  logic                     osc_edge;      // one-cycle transition pulse
  logic [2:0]               pins_sync;     // synchronised mode pins
  logic [2:0]               mode_ff;       // reset-latched mode code
  logic [`OCW_CFG_WIDTH-1:0] cfg_ff;       // system config register
  logic [MON_CNT_WIDTH-1:0] mon_cnt_ff;    // loss monitor counter
  ocw_src_type              src_ff;        // cpu clock source
  ocw_src_type              nxt_src;       // next source
  logic                     irq_ff;        // sticky failure request
  logic [3:0]               trans_cnt_ff;  // input transitions since resync
  logic                     div_ff;        // prescaler phase
  ocw_kind_type             kind;          // decoded generation kind
  logic [3:0]               factor_x2;     // decoded pll factor
  logic                     mon_dis;       // monitor disable bit
  logic                     mon_active;    // counter is running
  logic                     mon_ovf;       // overflow this cycle
  logic                     rise;          // rising oscillator edge
  logic [MON_CNT_WIDTH:0]   quiet_run_ff;  // helper: quiet monitor cycles in a row

  // elaboration check: overflow is the counter wrapping, so the count
  // must be a power of two matching the counter width
  if (MON_OVF_CYCLES != (1 << MON_CNT_WIDTH))
  begin : g_ovf_check
    $error("monitor overflow count must equal two to the counter width");
  end

  ////////////////////////////////////////////////////////////////////////
  // mode decode
  // kind from the latched code; pll for every code but the two direct ones
  function automatic ocw_kind_type mode_kind(input logic [2:0] code);
    case (code)
      `OCW_MODE_DIRECT:   mode_kind = OCW_KIND_DIRECT;
      `OCW_MODE_PRESCALE: mode_kind = OCW_KIND_PRESCALE;
      default:            mode_kind = OCW_KIND_PLL;
    endcase
  endfunction : mode_kind

  // pll factor times two, so 1.5 and 2.5 stay whole numbers
  function automatic logic [3:0] mode_factor_x2(input logic [2:0] code);
    case (code)
      `OCW_MODE_X4:   mode_factor_x2 = `OCW_FX2_X4;
      `OCW_MODE_X3:   mode_factor_x2 = `OCW_FX2_X3;
      `OCW_MODE_X2:   mode_factor_x2 = `OCW_FX2_X2;
      `OCW_MODE_X5:   mode_factor_x2 = `OCW_FX2_X5;
      `OCW_MODE_X1P5: mode_factor_x2 = `OCW_FX2_X1P5;
      `OCW_MODE_X2P5: mode_factor_x2 = `OCW_FX2_X2P5;
      default:        mode_factor_x2 = `OCW_FX2_NONE;
    endcase
  endfunction : mode_factor_x2

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  ocw_sync #(.WIDTH(1)) u_osc_sync
  (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (1'b0),
    .i_async   (i_osc_input_pin),
    .o_sync    (osc_sync),
    .o_edge    (osc_edge)
  );

  // kept running through reset so the pins are settled when latched
  ocw_sync #(.WIDTH(3)) u_pin_sync
  (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (1'b0),
    .i_async   (i_clock_mode_pins),
    .o_sync    (pins_sync),
    .o_edge    ()
  );

  assign kind      = mode_kind(mode_ff);
  assign factor_x2 = mode_factor_x2(mode_ff);
  assign mon_dis   = cfg_ff[`OCW_CFG_MON_DIS_BIT];
  assign rise      = osc_edge & osc_sync;

  ////////////////////////////////////////////////////////////////////////
  // mode latch: follows the pins while reset is held, frozen after
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      mode_ff <= pins_sync;
  end

  ////////////////////////////////////////////////////////////////////////
  // system config register; reset clears the disable bit
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      cfg_ff <= `OCW_CFG_RESET;
    else if (i_cfg_wr)
      cfg_ff <= i_cfg_wdata;
  end

  ////////////////////////////////////////////////////////////////////////
  // loss monitor
  // runs only in the direct kinds, while enabled and still on the oscillator
  assign mon_active = (kind != OCW_KIND_PLL) & ~mon_dis
                      & (src_ff == OCW_SRC_OSC);
  assign mon_ovf    = mon_active & ~osc_edge
                      & (mon_cnt_ff == {MON_CNT_WIDTH{1'b1}});

  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      mon_cnt_ff <= '0;
    else if (!mon_active || osc_edge)
      mon_cnt_ff <= '0;
    else
      mon_cnt_ff <= mon_cnt_ff + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // source state machine; the only way out of pll free-run is reset
  always_comb
  begin
    nxt_src = src_ff;
    case (src_ff)
      OCW_SRC_OSC:
      begin
        if (mon_ovf)
          nxt_src = OCW_SRC_PLL_FREE;
      end
      OCW_SRC_PLL_FREE: nxt_src = OCW_SRC_PLL_FREE;
      OCW_SRC_PLL_LOCK: nxt_src = OCW_SRC_PLL_LOCK;
      default:          nxt_src = OCW_SRC_OSC;
    endcase
  end

  // reset picks the source from the pins as they are being latched
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      src_ff <= (mode_kind(pins_sync) == OCW_KIND_PLL) ? OCW_SRC_PLL_LOCK
                                                        : OCW_SRC_OSC;
    else
      src_ff <= nxt_src;
  end

  ////////////////////////////////////////////////////////////////////////
  // failure request flag; a new overflow beats a clear in the same cycle
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      irq_ff <= 1'b0;
    else if (mon_ovf)
      irq_ff <= 1'b1;
    else if (i_irq_clr)
      irq_ff <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // prescaler phase: toggles on each rising input edge
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      div_ff <= 1'b0;
    else if (rise)
      div_ff <= ~div_ff;
  end

  // pll resync: factor-th period is 2F transitions, counted both edges
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst || src_ff != OCW_SRC_PLL_LOCK)
      trans_cnt_ff <= '0;
    else if (osc_edge)
    begin
      if (trans_cnt_ff == factor_x2 - 4'h1)
        trans_cnt_ff <= '0;
      else
        trans_cnt_ff <= trans_cnt_ff + 4'h1;
    end
  end

  assign o_pll_resync = (src_ff == OCW_SRC_PLL_LOCK) & osc_edge
                        & (trans_cnt_ff == factor_x2 - 4'h1);

  ////////////////////////////////////////////////////////////////////////
  // cpu clock tick: one input period direct, two prescaled, every cycle on pll
  always_comb
  begin
    case (src_ff)
      OCW_SRC_OSC:
        o_cpu_clk_tick = (kind == OCW_KIND_PRESCALE) ? (rise & div_ff)
                                                     : rise;
      OCW_SRC_PLL_FREE: o_cpu_clk_tick = 1'b1;
      OCW_SRC_PLL_LOCK: o_cpu_clk_tick = 1'b1;
      default:          o_cpu_clk_tick = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign o_system_config_reg = cfg_ff;
  assign o_osc_fail_irq      = irq_ff;
  assign o_status.src        = src_ff;
  assign o_status.kind       = kind;
  assign o_status.factor_x2  = (src_ff == OCW_SRC_PLL_LOCK) ? factor_x2
                                                            : `OCW_FX2_NONE;
  // pll off only in a direct kind with the monitor disabled and no failover
  assign o_status.pll_on     = (kind == OCW_KIND_PLL) | ~mon_dis
                               | (src_ff == OCW_SRC_PLL_FREE);
  assign o_status.mon_on     = mon_active;

  ////////////////////////////////////////////////////////////////////////
  // assertion helper: counts quiet active cycles on its own, so the
  // overflow check does not lean on the monitor counter it guards;
  // saturates rather than wrapping so a long run cannot alias
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst || !mon_active || osc_edge)
      quiet_run_ff <= '0;
    else if (quiet_run_ff != {(MON_CNT_WIDTH+1){1'b1}})
      quiet_run_ff <= quiet_run_ff + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions
  a_ovf_switches_src: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    mon_ovf |=> (src_ff == OCW_SRC_PLL_FREE) && irq_ff)
    else $error("overflow did not switch source");
  a_sixteen_quiet: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    mon_active && !osc_edge
    && quiet_run_ff == (MON_CNT_WIDTH+1)'(MON_OVF_CYCLES - 1) |-> mon_ovf)
    else $error("no overflow after sixteen quiet cycles");
  a_irq_set_wins: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    mon_ovf && i_irq_clr |=> irq_ff)
    else $error("clear beat a new overflow");
  a_cfg_takes_write: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    i_cfg_wr |=> cfg_ff == $past(i_cfg_wdata))
    else $error("config write did not land");
  a_edge_clears: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    osc_edge |=> mon_cnt_ff == '0 && src_ff == $past(src_ff))
    else $error("transition did not clear the counter");
  a_count_steps: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    mon_active && !osc_edge && !mon_ovf |=> mon_cnt_ff == $past(mon_cnt_ff) + 1'b1)
    else $error("counter did not step");
  a_free_sticky: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    src_ff == OCW_SRC_PLL_FREE |=> src_ff == OCW_SRC_PLL_FREE)
    else $error("left pll free-run without reset");
  a_disabled_stays: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    mon_dis && src_ff == OCW_SRC_OSC |=> src_ff == OCW_SRC_OSC && !mon_ovf)
    else $error("failover while monitor disabled");
  a_pll_power_off: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    mon_dis && kind != OCW_KIND_PLL && src_ff == OCW_SRC_OSC |-> !o_status.pll_on)
    else $error("pll powered while monitor disabled");
  a_reset_enables: assert property (@(posedge i_clk_sys)
    i_sys_rst ##1 !i_sys_rst |-> !mon_dis)
    else $error("monitor not enabled after reset");
  a_mode_frozen: assert property (@(posedge i_clk_sys)
    !i_sys_rst |=> $stable(mode_ff))
    else $error("mode changed outside reset");
  a_pll_kind_src: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    kind == OCW_KIND_PLL |-> src_ff == OCW_SRC_PLL_LOCK && !mon_active)
    else $error("pll kind not sourcing cpu clock");
  a_direct_only: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    mon_active |-> kind != OCW_KIND_PLL)
    else $error("monitor active in pll mode");
endmodule : ocw_clock_select

/* File: verif/ocw_osc_model.sv */
// Purpose: external clock source feeding the oscillator input pin
// Assumes: free-running square wave, asynchronous to the system clock
// Notes:   dropping i_run freezes the pin at its last level, as a dead source does
`timescale 1ns/1ps
module ocw_osc_model
#(
  parameter int HALF_NS = 250  // half period, 2.5 system cycles
)
(
  input  wire logic i_run,     // source alive
  output logic      o_osc      // level on the oscillator input pin
);
  ////////////////////////////////////////////////////////////////////////////
  // toggle every half period while alive; a fixed phase offset keeps the
  // edges away from the system clock edges
  initial
  begin
    o_osc = 1'b0;
    #37;
    forever
    begin
      #(HALF_NS);
      if (i_run)
        o_osc = ~o_osc;
    end
  end
endmodule : ocw_osc_model

/* File: verif/testbench.sv */
// Purpose: self-checking bench for the cpu clock select and loss monitor
// Assumes: oscillator period of 5 system cycles from the source model
// Notes:   tick and resync counts allow one count of slack for window phase
`timescale 1ns/1ps
`include "ocw_defines.svh"
module testbench;
  import ocw_pkg::*;
  typedef struct packed
  {
    logic [2:0] code;  // mode pins during reset
    logic [2:0] kind;  // expected generation kind
    logic [2:0] src;   // expected cpu source
    logic [3:0] fx2;   // expected factor times two
    logic       mon;   // expected monitor active
    logic [7:0] tk;    // expected ticks in 100 cycles
  } ocw_tb_row_type;
  ocw_tb_row_type rows [0:7] = '{
    '{`OCW_MODE_X4, OCW_KIND_PLL, OCW_SRC_PLL_LOCK, `OCW_FX2_X4, 1'b0, 8'h64},
    '{`OCW_MODE_X3, OCW_KIND_PLL, OCW_SRC_PLL_LOCK, `OCW_FX2_X3, 1'b0, 8'h64},
    '{`OCW_MODE_X2, OCW_KIND_PLL, OCW_SRC_PLL_LOCK, `OCW_FX2_X2, 1'b0, 8'h64},
    '{`OCW_MODE_X5, OCW_KIND_PLL, OCW_SRC_PLL_LOCK, `OCW_FX2_X5, 1'b0, 8'h64},
    '{`OCW_MODE_DIRECT, OCW_KIND_DIRECT, OCW_SRC_OSC, `OCW_FX2_NONE, 1'b1, 8'h14},
    '{`OCW_MODE_X1P5, OCW_KIND_PLL, OCW_SRC_PLL_LOCK, `OCW_FX2_X1P5, 1'b0, 8'h64},
    '{`OCW_MODE_PRESCALE, OCW_KIND_PRESCALE, OCW_SRC_OSC, `OCW_FX2_NONE, 1'b1, 8'h0A},
    '{`OCW_MODE_X2P5, OCW_KIND_PLL, OCW_SRC_PLL_LOCK, `OCW_FX2_X2P5, 1'b0, 8'h64}};
  logic                      clk_sys;      // system and pll free-running clock
  logic                      sys_rst;      // hardware reset
  logic                      osc_run;      // source model alive
  logic                      osc_pin;      // oscillator input
  logic [2:0]                mode_pins;    // clock mode pins
  logic                      cfg_wr;       // config write strobe
  logic [`OCW_CFG_WIDTH-1:0] cfg_wdata;    // config write data
  logic                      irq_clr;      // failure flag clear
  logic [`OCW_CFG_WIDTH-1:0] cfg_reg;      // config register seen
  logic                      fail_irq;     // failure flag seen
  logic                      cpu_tick;     // cpu clock tick
  logic                      pll_resync;   // resync pulse
  ocw_status_type            status;       // status bundle
  int                        err_total;    // mismatches
  int                        comparisons;  // compares made
  int                        cycles;       // timeout counter
  int                        tk;           // ticks in last window
  int                        rs;           // resyncs in last window
  int                        w;            // bounded wait count
  ////////////////////////////////////////////////////////////////////////////
  ocw_osc_model #(.HALF_NS(250)) osc_u (.i_run(osc_run), .o_osc(osc_pin));
  ocw_clock_select dut_u
  (
    .i_clk_sys           (clk_sys),
    .i_sys_rst           (sys_rst),
    .i_osc_input_pin     (osc_pin),
    .i_clock_mode_pins   (mode_pins),
    .i_cfg_wr            (cfg_wr),
    .i_cfg_wdata         (cfg_wdata),
    .i_irq_clr           (irq_clr),
    .o_system_config_reg (cfg_reg),
    .o_osc_fail_irq      (fail_irq),
    .o_cpu_clk_tick      (cpu_tick),
    .o_pll_resync        (pll_resync),
    .o_status            (status)
  );
  ////////////////////////////////////////////////////////////////////////////
  // 100 ns clock; a hang is cut short well past the expected run length
  initial
  begin
    clk_sys = 1'b0;
    forever
      #50 clk_sys = ~clk_sys;
  end
  initial
    cycles = 0;
  always @(posedge clk_sys)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      err_total = err_total + 1;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp,
                     input int tol);
    logic ok;
    ok = (seen === exp) || (tol > 0 && seen + tol >= exp && seen <= exp + tol);
    comparisons = comparisons + 1;
    if (ok !== 1'b1)
    begin
      err_total = err_total + 1;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : chk
  // reset held 8 cycles with the mode pins set throughout
  task automatic do_reset(input logic [2:0] code);
    @(negedge clk_sys);
    mode_pins = code;
    sys_rst = 1'b1;
    repeat (8) @(negedge clk_sys);
    sys_rst = 1'b0;
    @(negedge clk_sys);
  endtask : do_reset
  // count ticks and resync pulses, sampled where settled
  task automatic window(input int n);
    tk = 0;
    rs = 0;
    repeat (n)
    begin
      @(negedge clk_sys);
      tk = tk + int'(cpu_tick === 1'b1);
      rs = rs + int'(pll_resync === 1'b1);
    end
  endtask : window
  task automatic give_verdict();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    err_total = 0;
    comparisons = 0;
    sys_rst = 1'b1;
    osc_run = 1'b1;
    mode_pins = `OCW_MODE_DEFAULT;
    cfg_wr = 1'b0;
    cfg_wdata = 16'h0000;
    irq_clr = 1'b0;
    // every mode code: kind, source, factor, monitor, cpu tick rate, resync rate
    foreach (rows[i])
    begin
      do_reset(rows[i].code);
      chk("kind", status.kind, rows[i].kind, 0);
      chk("src", status.src, rows[i].src, 0);
      chk("factor", status.factor_x2, rows[i].fx2, 0);
      chk("mon_on", status.mon_on, rows[i].mon, 0);
      chk("pll_on", status.pll_on, 1'b1, 0);
      chk("cfg", cfg_reg, `OCW_CFG_RESET, 0);
      chk("irq", fail_irq, 1'b0, 0);
      window(100);
      chk("ticks", 16'(tk), 16'(rows[i].tk), 1);
      chk("resync", 16'(rs), 16'((rows[i].fx2 == 0) ? 0 : 40 / rows[i].fx2), 1);
      chk("src run", status.src, rows[i].src, 0);
    end
    // lost clock in direct mode: overflow after 16 silent cycles
    do_reset(`OCW_MODE_DIRECT);
    osc_run = 1'b0;
    repeat (12) @(negedge clk_sys);
    chk("src early", status.src, OCW_SRC_OSC, 0);
    w = 0;
    // clear held across the overflow edge: the new failure must win
    irq_clr = 1'b1;
    while (status.src !== OCW_SRC_PLL_FREE && w < 12)
    begin
      @(negedge clk_sys);
      w = w + 1;
    end
    chk("src fail", status.src, OCW_SRC_PLL_FREE, 0);
    chk("irq fail", fail_irq, 1'b1, 0);
    irq_clr = 1'b0;
    window(20);
    chk("free ticks", 16'(tk), 16'h0014, 0);
    // clock returns: no switch back
    osc_run = 1'b1;
    repeat (50) @(negedge clk_sys);
    chk("src stays", status.src, OCW_SRC_PLL_FREE, 0);
    irq_clr = 1'b1;
    @(negedge clk_sys);
    irq_clr = 1'b0;
    @(negedge clk_sys);
    chk("irq clr", fail_irq, 1'b0, 0);
    do_reset(`OCW_MODE_DIRECT);
    chk("src reset", status.src, OCW_SRC_OSC, 0);
    // monitor disabled in prescale mode: pll off, no failover
    do_reset(`OCW_MODE_PRESCALE);
    cfg_wr = 1'b1;
    cfg_wdata = 16'h0010;
    @(negedge clk_sys);
    cfg_wr = 1'b0;
    @(negedge clk_sys);
    chk("cfg dis", cfg_reg, 16'h0010, 0);
    chk("mon off", status.mon_on, 1'b0, 0);
    chk("pll off", status.pll_on, 1'b0, 0);
    osc_run = 1'b0;
    repeat (40) @(negedge clk_sys);
    window(20);
    chk("src dis", status.src, OCW_SRC_OSC, 0);
    chk("irq dis", fail_irq, 1'b0, 0);
    chk("ticks dis", 16'(tk), 16'h0000, 0);
    osc_run = 1'b1;
    repeat (10) @(negedge clk_sys);
    cfg_wr = 1'b1;
    cfg_wdata = 16'h0000;
    @(negedge clk_sys);
    cfg_wr = 1'b0;
    @(negedge clk_sys);
    chk("mon back", status.mon_on, 1'b1, 0);
    // pll mode: dead source never fails over
    do_reset(`OCW_MODE_X3);
    mode_pins = `OCW_MODE_DIRECT;
    osc_run = 1'b0;
    repeat (40) @(negedge clk_sys);
    chk("pll src", status.src, OCW_SRC_PLL_LOCK, 0);
    chk("pll irq", fail_irq, 1'b0, 0);
    chk("kind held", status.kind, OCW_KIND_PLL, 0);
    chk("fx2 held", status.factor_x2, `OCW_FX2_X3, 0);
    give_verdict();
  end
endmodule : testbench
